// File: hb_map.svh
// Register map, field positions and timing constants for the gate control block
`ifndef HB_MAP_SVH
`define HB_MAP_SVH

`define HB_ADDR_CTRL   6'h00
`define HB_ADDR_STAT   6'h10
`define HB_CTRL_MASK   16'h03df
`define HB_STAT_MASK   16'h03cc

`define HB_C_GATE_HI   9
`define HB_C_GATE_LO   6
`define HB_C_FW_SIDE   4
`define HB_C_FW_ACT    3
`define HB_C_OV_OFF    2
`define HB_C_UV_OFF    1
`define HB_C_MODE      0

`define HB_S_OC_HI     9
`define HB_S_OC_LO     6
`define HB_S_UV        3
`define HB_S_OV        2

`define HB_FRAME_BITS  24
`define HB_F_WR        23
`define HB_F_ADDR_HI   21
`define HB_F_ADDR_LO   16
`define HB_CNT_W       5

`define HB_G_FAULT     7
`define HB_G_FRERR     6
`define HB_G_RESETB    5
`define HB_G_SOC       1
`define HB_G_NOT_SETTLED_FLAG      0

`define HB_CLK_NS      100
`define HB_SETTLE_NS   50000
`define HB_SETTLE_CYC  (`HB_SETTLE_NS / `HB_CLK_NS)
`define HB_SETTLE_W    10

`define HB_SYNC_W      11
`define HB_SYNC_RST    11'h001

`define HB_FW_LOW      4'h5
`define HB_FW_HIGH     4'ha

`endif

// File: hb_pkg.sv
// Types shared by the gate control block
`include "hb_map.svh"
package hb_pkg;

	typedef struct packed {
		logic [15:0]             ctrl;
		logic [3:0]              oc;
		logic                    uv_flag;
		logic                    ov_flag;
		logic                    frame_err;
		logic                    not_settled;
		logic [`HB_SETTLE_W-1:0] settle_cnt;
		logic                    csn_q;
		logic                    start_seen;
		logic                    done_seen;
		logic                    over_seen;
		logic [15:0]             tx_data;
		logic [23:0]             tx_word;
		logic [3:0]              gate;
		logic                    active;
	} hb_top_state_type;

	typedef struct packed {
		logic [23:0] sh;
		logic [23:0] rx;
		logic        start_tog;
		logic        done_tog;
		logic        over_tog;
	} hb_link_state_type;

	typedef struct packed {
		logic [`HB_SYNC_W-1:0] stage1;
		logic [`HB_SYNC_W-1:0] stage2;
	} hb_sync_state_type;

endpackage

// File: hb_sync.sv
// Two-stage synchroniser for pins and link-domain toggles
`timescale 1ns/1ps
`include "hb_map.svh"
module hb_sync import hb_pkg::*; (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	// Asynchronous inputs and their synchronised copies
	input  wire logic [`HB_SYNC_W-1:0] i_async,
	output logic      [`HB_SYNC_W-1:0] o_sync
);
	hb_sync_state_type q;
	hb_sync_state_type next_q;

	// Second stage reads only the first
	always_comb begin
		next_q.stage1 = i_async;
		next_q.stage2 = q.stage1;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q <= {`HB_SYNC_RST, `HB_SYNC_RST};
		end else begin
			q <= next_q;
		end
	end

	assign o_sync = q.stage2;
endmodule

// File: hb_link.sv
// Serial clock domain: frame shifter, bit counter and data output
`timescale 1ns/1ps
`include "hb_map.svh"
module hb_link import hb_pkg::*; (
	// Serial pins
	input  wire logic        i_sclk,
	input  wire logic        i_csn,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	// Reset from the system side
	input  wire logic        i_sys_rst,
	// Quasi-static words from and to the system side
	input  wire logic [23:0] i_tx_word,
	output logic      [23:0] o_rx_word,
	output logic             o_start_tog,
	output logic             o_done_tog,
	output logic             o_over_tog
);
	hb_link_state_type       q;
	hb_link_state_type       next_q;
	logic [`HB_CNT_W-1:0]    cnt;
	logic                    sdo_bit;

	// Edge counter, cleared while the frame is closed
	always_ff @(posedge i_sclk or posedge i_csn) begin
		if (i_csn) begin
			cnt <= '0;
		end else if (cnt != `HB_CNT_W'(`HB_FRAME_BITS + 1)) begin
			cnt <= cnt + `HB_CNT_W'(1);
		end
	end

	always_comb begin
		next_q = q;
		next_q.sh = {q.sh[22:0], i_sdi};
		if (cnt == '0) begin
			next_q.start_tog = ~q.start_tog;
		end
		if (cnt == `HB_CNT_W'(`HB_FRAME_BITS - 1)) begin
			next_q.rx       = {q.sh[22:0], i_sdi};
			next_q.done_tog = ~q.done_tog;
		end
		if (cnt == `HB_CNT_W'(`HB_FRAME_BITS)) begin
			next_q.over_tog = ~q.over_tog;
		end
	end

	always_ff @(posedge i_sclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Data changes on the falling edge for the master to sample on the rising
	always_ff @(negedge i_sclk) begin
		if (cnt != '0 && cnt < `HB_CNT_W'(`HB_FRAME_BITS)) begin
			sdo_bit <= i_tx_word[`HB_CNT_W'(`HB_FRAME_BITS - 1) - cnt];
		end else begin
			sdo_bit <= 1'b0;
		end
	end

	// Before the first edge the fault bit is shown
	assign o_sdo       = (cnt == '0) ? i_tx_word[`HB_F_WR] : sdo_bit;
	assign o_rx_word   = q.rx;
	assign o_start_tog = q.start_tog;
	assign o_done_tog  = q.done_tog;
	assign o_over_tog  = q.over_tog;
endmodule

// File: hb_ctrl_top.sv
// Gate control and fault status registers of the H-bridge pre-driver
`timescale 1ns/1ps
`include "hb_map.svh"
module hb_ctrl_top import hb_pkg::*; (
	// System clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// Serial link
	input  wire logic       i_sclk,
	input  wire logic       i_csn,
	input  wire logic       i_sdi,
	output logic            o_sdo,
	// Drive and fault pins
	input  wire logic       i_pwm,
	input  wire logic       i_undervolt,
	input  wire logic       i_overvolt,
	input  wire logic [3:0] i_overcurrent,
	// Gate outputs
	output logic            o_gate_high_a,
	output logic            o_gate_low_a,
	output logic            o_gate_high_b,
	output logic            o_gate_low_b,
	output logic            o_active
);
	hb_top_state_type       q;
	hb_top_state_type       next_q;
	logic [23:0]            rx_word;
	logic                   start_tog;
	logic                   done_tog;
	logic                   over_tog;
	logic [`HB_SYNC_W-1:0]  sync_out;
	logic                   csn_s;
	logic                   pwm_s;
	logic                   uv_s;
	logic                   ov_s;
	logic [3:0]             oc_s;
	logic                   start_s;
	logic                   done_s;
	logic                   over_s;
	logic                   frame_end;
	logic                   frame_started;
	logic                   frame_good;
	logic                   frame_bad;
	logic                   wr_ctrl;
	logic                   rd_stat;
	logic                   mode_off_wr;
	logic                   clr_status;
	logic [5:0]             addr;
	logic [15:0]            ctrl_wdata;
	logic [15:0]            stat_view;
	logic [15:0]            rd_data;
	logic [3:0]             cmd;
	logic                   supply_block;
	logic                   run;
	logic                   comb_fault;
	logic [7:0]             glob;

	hb_link u_link (
		.i_sclk      (i_sclk),
		.i_csn       (i_csn),
		.i_sdi       (i_sdi),
		.o_sdo       (o_sdo),
		.i_sys_rst   (i_sys_rst),
		.i_tx_word   (q.tx_word),
		.o_rx_word   (rx_word),
		.o_start_tog (start_tog),
		.o_done_tog  (done_tog),
		.o_over_tog  (over_tog)
	);

	hb_sync u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({over_tog, done_tog, start_tog, i_overcurrent,
			i_overvolt, i_undervolt, i_pwm, i_csn}),
		.o_sync    (sync_out)
	);

	assign csn_s   = sync_out[0];
	assign pwm_s   = sync_out[1];
	assign uv_s    = sync_out[2];
	assign ov_s    = sync_out[3];
	assign oc_s    = sync_out[7:4];
	assign start_s = sync_out[8];
	assign done_s  = sync_out[9];
	assign over_s  = sync_out[10];

	always_comb begin
		next_q = q;
		// Frame closes: judge length from the link toggles
		frame_end     = csn_s && !q.csn_q;
		frame_started = frame_end && (start_s != q.start_seen);
		frame_good    = frame_started && (done_s != q.done_seen)
			&& (over_s == q.over_seen);
		frame_bad     = frame_started && !frame_good;
		addr          = rx_word[`HB_F_ADDR_HI:`HB_F_ADDR_LO];
		wr_ctrl       = frame_good && rx_word[`HB_F_WR] && addr == `HB_ADDR_CTRL;
		rd_stat       = frame_good && !rx_word[`HB_F_WR] && addr == `HB_ADDR_STAT;
		ctrl_wdata    = rx_word[15:0] & `HB_CTRL_MASK;
		mode_off_wr   = wr_ctrl && !ctrl_wdata[`HB_C_MODE];
		clr_status    = rd_stat || mode_off_wr;
		next_q.csn_q  = csn_s;
		if (frame_end) begin
			next_q.start_seen = start_s;
			next_q.done_seen  = done_s;
			next_q.over_seen  = over_s;
		end

		// Status register view
		stat_view = 16'h0000;
		stat_view[`HB_S_OC_HI:`HB_S_OC_LO] = q.oc;
		stat_view[`HB_S_UV] = q.uv_flag;
		stat_view[`HB_S_OV] = q.ov_flag;
		rd_data = 16'h0000;
		if (addr == `HB_ADDR_CTRL) begin
			rd_data = q.ctrl;
		end else if (addr == `HB_ADDR_STAT) begin
			rd_data = stat_view;
		end
		if (frame_good) begin
			next_q.tx_data = rd_data;
		end

		// Control writes; mode zero wipes the register contents
		if (wr_ctrl) begin
			next_q.ctrl = mode_off_wr ? 16'h0000 : ctrl_wdata;
		end
		if (frame_good) begin
			next_q.frame_err = 1'b0;
		end
		if (mode_off_wr) begin
			next_q.frame_err = 1'b0;
		end
		if (frame_bad) begin
			next_q.frame_err = 1'b1;
		end

		// Latched flags: a live event wins over the clear
		if (clr_status) begin
			next_q.oc      = 4'h0;
			next_q.uv_flag = 1'b0;
			next_q.ov_flag = 1'b0;
		end
		next_q.oc      = next_q.oc | oc_s;
		next_q.uv_flag = next_q.uv_flag | uv_s;
		next_q.ov_flag = next_q.ov_flag | ov_s;

		// Settling timer after leaving standby
		if (!next_q.ctrl[`HB_C_MODE]) begin
			next_q.not_settled = 1'b1;
			next_q.settle_cnt  = `HB_SETTLE_W'(`HB_SETTLE_CYC - 1);
		end else if (q.not_settled) begin
			if (q.settle_cnt == '0) begin
				next_q.not_settled = 1'b0;
			end else begin
				next_q.settle_cnt = q.settle_cnt - `HB_SETTLE_W'(1);
			end
		end

		// Enable pairs decoded per half-bridge
		cmd[3] = q.ctrl[`HB_C_GATE_HI] & ~q.ctrl[`HB_C_GATE_HI - 1];
		cmd[2] = q.ctrl[`HB_C_GATE_HI - 1] & ~q.ctrl[`HB_C_GATE_HI];
		cmd[1] = q.ctrl[`HB_C_GATE_LO + 1] & ~q.ctrl[`HB_C_GATE_LO];
		cmd[0] = q.ctrl[`HB_C_GATE_LO] & ~q.ctrl[`HB_C_GATE_LO + 1];
		if (!pwm_s) begin
			if (q.ctrl[`HB_C_FW_ACT]) begin
				if (q.ctrl[`HB_C_FW_SIDE]) begin
					cmd = `HB_FW_HIGH;
				end else begin
					cmd = `HB_FW_LOW;
				end
			end else begin
				if (q.ctrl[`HB_C_FW_SIDE]) begin
					cmd = cmd & `HB_FW_HIGH;
				end else begin
					cmd = cmd & `HB_FW_LOW;
				end
			end
		end

		// Supply lockout: live fault, or latched with restart off
		supply_block = uv_s || ov_s
			|| (q.ctrl[`HB_C_UV_OFF] && q.uv_flag)
			|| (q.ctrl[`HB_C_OV_OFF] && q.ov_flag);
		run = q.ctrl[`HB_C_MODE] && !q.not_settled && !supply_block;
		next_q.gate   = run ? (cmd & ~(q.oc | oc_s)) : 4'h0;
		next_q.active = q.ctrl[`HB_C_MODE];

		// Global status byte returned in the next frame
		comb_fault = q.uv_flag || q.ov_flag || (q.oc != 4'h0);
		glob = 8'h00;
		glob[`HB_G_SOC]    = comb_fault;
		glob[`HB_G_NOT_SETTLED_FLAG]   = q.not_settled;
		glob[`HB_G_FRERR]  = q.frame_err;
		glob[`HB_G_RESETB] = 1'b1;
		glob[`HB_G_FAULT]  = comb_fault || q.frame_err;
		if (csn_s && q.csn_q) begin
			next_q.tx_word = {glob, q.tx_data};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q <= '0;
			q.not_settled <= 1'b1;
			q.settle_cnt  <= `HB_SETTLE_W'(`HB_SETTLE_CYC - 1);
			q.csn_q       <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign o_gate_high_a = q.gate[3];
	assign o_gate_low_a  = q.gate[2];
	assign o_gate_high_b = q.gate[1];
	assign o_gate_low_b  = q.gate[0];
	assign o_active      = q.active;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_pair_exclusive;
		!(o_gate_high_a && o_gate_low_a) && !(o_gate_high_b && o_gate_low_b);
	endproperty
	a_pair_exclusive: assert property (p_pair_exclusive)
		else $error("high and low gate on together");

	property p_fw_low_active;
		(run && !pwm_s && q.ctrl[`HB_C_FW_ACT] && !q.ctrl[`HB_C_FW_SIDE]
			&& q.oc == 4'h0 && oc_s == 4'h0) |=> (q.gate == `HB_FW_LOW);
	endproperty
	a_fw_low_active: assert property (p_fw_low_active)
		else $error("low-side active freewheel wrong");

	property p_fw_high_active;
		(run && !pwm_s && q.ctrl[`HB_C_FW_ACT] && q.ctrl[`HB_C_FW_SIDE]
			&& q.oc == 4'h0 && oc_s == 4'h0) |=> (q.gate == `HB_FW_HIGH);
	endproperty
	a_fw_high_active: assert property (p_fw_high_active)
		else $error("high-side active freewheel wrong");

	property p_ov_lockout;
		(q.ctrl[`HB_C_OV_OFF] && q.ov_flag) |=> (q.gate == 4'h0);
	endproperty
	a_ov_lockout: assert property (p_ov_lockout)
		else $error("gates on during over-voltage lockout");

	property p_uv_lockout;
		(q.ctrl[`HB_C_UV_OFF] && q.uv_flag) |=> (q.gate == 4'h0);
	endproperty
	a_uv_lockout: assert property (p_uv_lockout)
		else $error("gates on during under-voltage lockout");

	property p_standby_off;
		!q.ctrl[`HB_C_MODE] |=> (q.gate == 4'h0) && !o_active ##1 q.not_settled;
	endproperty
	a_standby_off: assert property (p_standby_off)
		else $error("outputs active in standby");

	property p_oc_latch;
		oc_s[3] |=> q.oc[3] && !o_gate_high_a ##1 !o_gate_high_a;
	endproperty
	a_oc_latch: assert property (p_oc_latch)
		else $error("over-current flag or cut-off missing");

	property p_oc_hold;
		(q.oc[2] && !clr_status) |=> q.oc[2] && !o_gate_low_a;
	endproperty
	a_oc_hold: assert property (p_oc_hold)
		else $error("over-current output came back");

	property p_uv_event;
		uv_s |=> q.uv_flag && (q.gate == 4'h0);
	endproperty
	a_uv_event: assert property (p_uv_event)
		else $error("under-voltage did not cut outputs");

	property p_ov_event;
		ov_s |=> q.ov_flag && (q.gate == 4'h0);
	endproperty
	a_ov_event: assert property (p_ov_event)
		else $error("over-voltage did not cut outputs");

	property p_fw_passive_low;
		(run && !pwm_s && !q.ctrl[`HB_C_FW_ACT] && !q.ctrl[`HB_C_FW_SIDE])
			|=> ((q.gate & `HB_FW_HIGH) == 4'h0);
	endproperty
	a_fw_passive_low: assert property (p_fw_passive_low)
		else $error("high gate on in low-side passive freewheel");

	property p_fw_passive_high;
		(run && !pwm_s && !q.ctrl[`HB_C_FW_ACT] && q.ctrl[`HB_C_FW_SIDE])
			|=> ((q.gate & `HB_FW_LOW) == 4'h0);
	endproperty
	a_fw_passive_high: assert property (p_fw_passive_high)
		else $error("low gate on in high-side passive freewheel");

	property p_comb_fault;
		(csn_s && q.csn_q) |=> (q.tx_word[16 + `HB_G_SOC] ==
			$past(q.uv_flag || q.ov_flag || q.oc != 4'h0));
	endproperty
	a_comb_fault: assert property (p_comb_fault)
		else $error("combined fault bit wrong");

	property p_bad_frame;
		frame_bad |=> q.frame_err;
	endproperty
	a_bad_frame: assert property (p_bad_frame)
		else $error("short or long frame not flagged");

	property p_settle_block;
		($rose(q.ctrl[`HB_C_MODE])) |-> q.not_settled [*3] ##1 (q.gate == 4'h0);
	endproperty
	a_settle_block: assert property (p_settle_block)
		else $error("outputs on before settling");

	property p_ctrl_reserved;
		(q.ctrl & ~`HB_CTRL_MASK) == 16'h0000;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved)
		else $error("reserved control bit set");

	c_fw_active: cover property (run && !pwm_s && q.ctrl[`HB_C_FW_ACT]);
	c_oc_event: cover property (oc_s != 4'h0 ##[1:100] clr_status);
	c_bad_frame: cover property (frame_bad);
	c_auto_restart: cover property ($fell(uv_s) && !q.ctrl[`HB_C_UV_OFF] ##2 run);
endmodule

// File: hb_host_model.sv
// Host serial master model driving frames of nbits clocks
`timescale 1ns/1ps
module hb_host_model (
	// Serial pins towards the device
	output logic       o_sclk,
	output logic       o_csn,
	output logic       o_sdi,
	// Reply line from the device
	input  wire logic  i_sdo
);
	initial begin
		o_sclk = 1'b0;
		o_csn  = 1'b1;
		o_sdi  = 1'b0;
	end

	// Clock stands low between frames, 12 ns per bit, data shifted MSB first
	task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] rx);
		rx = 24'h000000;
		o_csn = 1'b0;
		#12;
		rx[23] = i_sdo;
		for (int i = 0; i < nbits; i++) begin
			o_sdi = (i < 24) ? word[23-i] : ~o_sdi;
			#6 o_sclk = 1'b1;
			if (i < 24) rx[23-i] = i_sdo;
			#6 o_sclk = 1'b0;
		end
		// Pull-down level once released
		o_sdi = 1'b0;
		#12 o_csn = 1'b1;
	endtask
endmodule

// File: tb_hbridge_gate_control_regs.sv
// Self-checking bench for the gate control register block
`timescale 1ns/1ps
module tb_hbridge_gate_control_regs import hb_pkg::*;;
	logic        i_clk;
	logic        i_sys_rst;
	logic        i_pwm;
	logic        i_undervolt;
	logic        i_overvolt;
	logic [3:0]  i_overcurrent;
	logic        sclk;
	logic        csn;
	logic        sdi;
	logic        sdo;
	logic        gha;
	logic        gla;
	logic        ghb;
	logic        glb;
	logic        o_active;
	logic [15:0] d;
	logic [7:0]  g;
	logic [23:0] r;
	int          bad_count;
	int          comparisons;
	logic [3:0]  fw_tab [4];

	hb_host_model host (.o_sclk(sclk), .o_csn(csn), .o_sdi(sdi), .i_sdo(sdo));

	hb_ctrl_top dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
		.o_sdo(sdo), .i_pwm(i_pwm), .i_undervolt(i_undervolt), .i_overvolt(i_overvolt),
		.i_overcurrent(i_overcurrent), .o_gate_high_a(gha), .o_gate_low_a(gla),
		.o_gate_high_b(ghb), .o_gate_low_b(glb), .o_active(o_active)
	);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic print_verdict;
		$display("counts: comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_g(input string what, input logic [3:0] exp);
		comparisons++;
		if ({gha, gla, ghb, glb} !== exp) begin
			bad_count++;
			$display("unexpected %s expected %b seen %b", what, exp, {gha, gla, ghb, glb});
		end
	endtask

	task automatic spi(input logic [23:0] w, input int n, output logic [23:0] rx);
		host.xfer(w, n, rx);
		tick(8);
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		logic [23:0] x;
		spi({2'b10, a, v}, 24, x);
	endtask

	// Global byte from the access frame, data from the following frame
	task automatic rd(input logic [5:0] a, output logic [15:0] v, output logic [7:0] gl);
		logic [23:0] x;
		spi({2'b00, a, 16'h0000}, 24, x);
		gl = x[23:16];
		spi(24'h000000, 24, x);
		v = x[15:0];
	endtask

	task automatic supply(input logic ov, input logic lock);
		logic [15:0] v;
		logic [7:0]  gl;
		wr(6'h00, 16'h0241 | (lock ? (ov ? 16'h0004 : 16'h0002) : 16'h0000));
		chk_g("gates before", 4'b1001);
		@(posedge i_clk) begin
			i_overvolt  <= ov;
			i_undervolt <= ~ov;
		end
		tick(4);
		chk_g("gates in supply fault", 4'b0000);
		@(posedge i_clk) begin
			i_overvolt  <= 1'b0;
			i_undervolt <= 1'b0;
		end
		tick(6);
		chk_g("gates after supply", lock ? 4'b0000 : 4'b1001);
		rd(6'h10, v, gl);
		chk("supply status", ov ? 16'h0004 : 16'h0008, v);
		chk_g("gates after clear", 4'b1001);
		$display("test supply ov=%0d lock=%0d done", ov, lock);
	endtask

	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		fw_tab = '{4'b0001, 4'b1000, 4'b0101, 4'b1010};
		bad_count = 0;
		comparisons = 0;
		i_sys_rst = 1'b1;
		i_pwm = 1'b1;
		i_undervolt = 1'b0;
		i_overvolt = 1'b0;
		i_overcurrent = 4'h0;
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		tick(4);
		rd(6'h00, d, g);
		chk("ctrl reset", 16'h0000, d);
		chk("global reset", 16'h0021, g);
		rd(6'h10, d, g);
		chk("status reset", 16'h0000, d);
		chk("active reset", 16'h0000, o_active);
		$display("test reset done");
		wr(6'h00, 16'hffff);
		chk("active", 16'h0001, o_active);
		rd(6'h00, d, g);
		chk("ctrl masked", 16'h03df, d);
		wr(6'h05, 16'hffff);
		rd(6'h05, d, g);
		chk("unmapped", 16'h0000, d);
		wr(6'h00, 16'h0241);
		chk_g("gates settling", 4'b0000);
		rd(6'h00, d, g);
		chk("global settling", 16'h0021, g);
		tick(500);
		chk_g("gates settled", 4'b1001);
		rd(6'h00, d, g);
		chk("global settled", 16'h0020, g);
		$display("test settle done");
		for (int i = 0; i < 16; i++) begin
			wr(6'h00, {6'h00, i[3:0], 6'h01});
			chk_g("gate decode", {i[3] & ~i[2], i[2] & ~i[3], i[1] & ~i[0], i[0] & ~i[1]});
		end
		$display("test decode done");
		@(posedge i_clk) i_pwm <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(6'h00, 16'h0241 | {11'h000, k[0], k[1], 3'b000});
			chk_g("freewheel", fw_tab[k]);
		end
		@(posedge i_clk) i_pwm <= 1'b1;
		wr(6'h00, 16'h0241);
		$display("test freewheel done");
		for (int j = 0; j < 4; j++) begin
			@(posedge i_clk) i_overcurrent <= 4'h1 << j;
			tick(3);
			@(posedge i_clk) i_overcurrent <= 4'h0;
			tick(20);
			chk_g("gates in current fault", 4'b1001 & ~(4'h1 << j));
			spi(24'h000000, 0, r);
			chk("poll fault", 16'h0001, r[23]);
			rd(6'h10, d, g);
			chk("current status", 16'h0040 << j, d);
			chk("current global", 16'h00a2, g);
			chk_g("gates after clear", 4'b1001);
			rd(6'h10, d, g);
			chk("status cleared", 16'h0000, d);
		end
		$display("test overcurrent done");
		supply(1'b0, 1'b0);
		supply(1'b0, 1'b1);
		supply(1'b1, 1'b0);
		supply(1'b1, 1'b1);
		for (int n = 23; n < 26; n += 2) begin
			spi(24'h80ffff, n, r);
			rd(6'h00, d, g);
			chk("ctrl after bad frame", 16'h0245, d);
			chk("global bad frame", 16'h00e0, g);
		end
		$display("test frame length done");
		@(posedge i_clk) i_overcurrent <= 4'h1;
		tick(3);
		@(posedge i_clk) i_overcurrent <= 4'h0;
		tick(4);
		wr(6'h00, 16'h0240);
		chk("active standby", 16'h0000, o_active);
		chk_g("gates standby", 4'b0000);
		rd(6'h00, d, g);
		chk("ctrl standby", 16'h0000, d);
		chk("global standby", 16'h0021, g);
		rd(6'h10, d, g);
		chk("status standby", 16'h0000, d);
		$display("test standby done");
		print_verdict();
	end
endmodule
